// ===== rtl/adst_ctrl.sv
// Scan trigger, enable, vector, DMA sizing and reference status control of the converter unit
//
// Implementation choices: the address-and-strobe port and the address map.

// How it works
// - Codes 0-7: none, software, scan, irq, timers
// - Codes 8-20 PWM, compare, trip; 24-29 CL; rest reserved
// - Scan trigger drives upper inputs only
// - Enable bit 15 turns module on
// - Idle stop bit halts module in idle
// - Bit 12 drives input charge pump, off
// - Bit 11 enables capacitive divider operation
// - Bit 10 bypasses DMA clock synchronisers
// - Bit 9 bypasses bus clock synchronisers
// - Vector read: base plus shifted lowest ID
// - Vector shift field gives zero to seven
// - Level mode rescans while selected trigger high
// - Edge mode: one scan per rising edge
// - DMA start: base plus ID shifted length+1
// - Buffer length gives two-power locations
// - Reference ready set by hardware, zero off
// - Fault sets while on, clears off ready
// - Scan done sets at end, read clears
// - Divider capacitor select drives shared inputs
module adst_ctrl (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdData,
	// Trigger sources, bit n belongs to select code n
	input  wire logic [31:0] trigSources,
	// Converter side
	input  wire logic        idleMode,
	input  wire logic        scanComplete,
	input  wire logic [31:0] inputReadyLow,
	input  wire logic [31:0] inputReadyHigh,
	output logic             scanStart,
	// Analog reference status pins
	input  wire logic        refReadyPin,
	input  wire logic        refFaultPin,
	// DMA address query
	input  wire logic [5:0]  dmaChanId,
	output logic      [31:0] dmaStartAddr,
	// Static controls
	output logic             moduleRun,
	output logic             inputPumpEnable,
	output logic             dividerSenseEnable,
	output logic             dmaClockSyncBypass,
	output logic             periphClockSyncBypass,
	output logic      [2:0]  dividerCapSelect
);

	logic [31:0] ctrlOne_q;
	logic [2:0]  capSel_q;
	logic [31:0] vecBase_q;
	logic [31:0] dmaBase_q;
	logic        swLevel_q;
	logic        swEdge_q;
	logic        refFault_q;
	logic        scanDone_q;
	logic        trigPrev_q;
	logic        pending_q;
	logic        active_q;
	logic        scanStart_q;
	logic [31:0] rdData_q;
	logic [31:0] dmaAddr_q;

	logic [4:0]  trigSel;
	logic [2:0]  vecShift;
	logic [2:0]  bufLen;
	logic        enable;
	logic        running;
	logic        levelMode;
	logic        trigLevel;
	logic        trigRise;
	logic        startNow;
	logic        refReadySync;
	logic        refFaultSync;
	logic        refReadyFlag;
	logic        wrHit;
	logic [31:0] vecRead;
	logic [31:0] ctrlOneRead;
	logic [31:0] ctrlTwoRead;

	// Lowest set input ID among the 64 data-ready flags
	function automatic logic [5:0] lowestId(input logic [63:0] flags);
		logic [5:0] id;
		id = 6'h00;
		for (int i = 63; i >= 0; i--) begin
			if (flags[i]) begin
				id = 6'(i);
			end
		end
		return id;
	endfunction

	// Register-port address match
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	// Writable bits of control one; the rest is not stored and reads zero
	function automatic logic [31:0] ctrlOneMask();
		logic [31:0] m;
		m = 32'h0000_0000;
		m[adst_pkg::TRIG_SEL_LSB +: adst_pkg::TRIG_SEL_W] = 5'h1f;
		m[adst_pkg::ENABLE_BIT]    = 1'b1;
		m[adst_pkg::IDLE_STOP_BIT] = 1'b1;
		m[adst_pkg::PUMP_BIT]      = 1'b1;
		m[adst_pkg::DIV_SENSE_BIT] = 1'b1;
		m[adst_pkg::DMA_BYP_BIT]   = 1'b1;
		m[adst_pkg::PER_BYP_BIT]   = 1'b1;
		m[adst_pkg::VEC_SHIFT_LSB +: 3] = 3'h7;
		m[adst_pkg::SENS_BIT]      = 1'b1;
		m[adst_pkg::BUF_LEN_LSB +: 3]   = 3'h7;
		return m;
	endfunction

	assign trigSel   = ctrlOne_q[adst_pkg::TRIG_SEL_LSB +: adst_pkg::TRIG_SEL_W];
	assign vecShift  = ctrlOne_q[adst_pkg::VEC_SHIFT_LSB +: 3];
	assign bufLen    = ctrlOne_q[adst_pkg::BUF_LEN_LSB +: 3];
	assign levelMode = ctrlOne_q[adst_pkg::SENS_BIT];
	assign enable    = ctrlOne_q[adst_pkg::ENABLE_BIT];
	assign running   = enable && !(ctrlOne_q[adst_pkg::IDLE_STOP_BIT] && idleMode);
	assign wrHit     = regWrite;

	// Analog status pins: three stages, a change counts once the last two agree
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gSync
			logic [adst_pkg::SYNC_STAGES-1:0] stage_q;
			// Filter kept per lane so that each lane has a driver of its own
			logic                             filt_q;
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					stage_q <= '0;
					filt_q  <= 1'b0;
				end else begin
					stage_q <= {stage_q[adst_pkg::SYNC_STAGES-2:0], (g == 0) ? refReadyPin : refFaultPin};
					if (stage_q[1] == stage_q[2]) begin
						filt_q <= stage_q[2];
					end
				end
			end
		end
	endgenerate
	assign refReadySync = gSync[0].filt_q;
	assign refFaultSync = gSync[1].filt_q;

	// Ready flag is forced low while the module is off
	assign refReadyFlag = enable && refReadySync;

	// Trigger source decode; reserved codes select nothing
	always_comb begin
		trigLevel = 1'b0;
		if (trigSel == adst_pkg::TRG_SW_EDGE) begin
			trigLevel = swEdge_q;
		end else if (trigSel == adst_pkg::TRG_SW_LEVEL) begin
			trigLevel = swLevel_q;
		end else if (trigSel == adst_pkg::TRG_SCAN || trigSel == adst_pkg::TRG_EXT_IRQ0 ||
				(trigSel >= adst_pkg::TRG_TMR_FIRST && trigSel <= adst_pkg::TRG_TMR_LAST)) begin
			trigLevel = trigSources[trigSel];
		end else if ((trigSel >= adst_pkg::TRG_PWM_FIRST && trigSel <= adst_pkg::TRG_OC_LAST) ||
				trigSel == adst_pkg::TRG_CTU_TRIP ||
				(trigSel >= adst_pkg::TRG_CL_FIRST && trigSel <= adst_pkg::TRG_CL_LAST)) begin
			trigLevel = trigSources[trigSel];
		end
	end

	assign trigRise = trigLevel && !trigPrev_q;
	// Level mode keeps restarting while the source stays high; edge mode waits for a latched edge
	assign startNow = running && !active_q && (levelMode ? trigLevel : pending_q);

	// Control one; turbo, format and resolution bits are outside this block and read zero
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrlOne_q <= adst_pkg::CTRL_ONE_RST;
		end else if (wrHit && hit(regAddr, adst_pkg::CTRL_ONE_OFS)) begin
			ctrlOne_q <= regWrData & ctrlOneMask();
		end
	end

	// Control two writable part
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			capSel_q <= adst_pkg::CAP_SEL_RST;
		end else if (wrHit && hit(regAddr, adst_pkg::CTRL_TWO_OFS)) begin
			capSel_q <= regWrData[adst_pkg::CAP_SEL_LSB +: 3];
		end
	end

	// Base registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			vecBase_q <= adst_pkg::BASE_RST;
			dmaBase_q <= adst_pkg::BASE_RST;
		end else begin
			if (wrHit && hit(regAddr, adst_pkg::VEC_BASE_OFS)) begin
				vecBase_q <= regWrData;
			end
			if (wrHit && hit(regAddr, adst_pkg::DMA_BASE_OFS)) begin
				dmaBase_q <= regWrData;
			end
		end
	end

	// Software triggers: the edge bit is a one-cycle pulse, the level bit holds
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			swEdge_q  <= 1'b0;
			swLevel_q <= 1'b0;
		end else begin
			swEdge_q <= wrHit && hit(regAddr, adst_pkg::SW_TRIG_OFS) && regWrData[adst_pkg::SW_EDGE_BIT];
			if (wrHit && hit(regAddr, adst_pkg::SW_TRIG_OFS)) begin
				swLevel_q <= regWrData[adst_pkg::SW_LEVEL_BIT];
			end
		end
	end

	// Scan sequencing; one scan in flight at a time
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			trigPrev_q  <= 1'b0;
			pending_q   <= 1'b0;
			active_q    <= 1'b0;
			scanStart_q <= 1'b0;
		end else begin
			trigPrev_q  <= trigLevel;
			scanStart_q <= startNow;
			if (!enable || levelMode) begin
				pending_q <= 1'b0;
			end else if (trigRise) begin
				pending_q <= 1'b1;
			end else if (startNow) begin
				pending_q <= 1'b0;
			end
			if (!enable) begin
				active_q <= 1'b0;
			end else if (startNow) begin
				active_q <= 1'b1;
			end else if (scanComplete) begin
				active_q <= 1'b0;
			end
		end
	end

	// Reference fault: a new fault wins over the clear condition
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			refFault_q <= 1'b0;
		end else if (enable && refFaultSync) begin
			refFault_q <= 1'b1;
		end else if (!enable && refReadySync) begin
			refFault_q <= 1'b0;
		end
	end

	// Scan done: completion in the read cycle keeps the flag set
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			scanDone_q <= 1'b0;
		end else if (scanComplete && active_q) begin
			scanDone_q <= 1'b1;
		end else if (regRead && hit(regAddr, adst_pkg::CTRL_TWO_OFS)) begin
			scanDone_q <= 1'b0;
		end
	end

	// Vector read value from the lowest pending input
	assign vecRead = vecBase_q + (32'(lowestId({inputReadyHigh, inputReadyLow})) << vecShift);

	// DMA buffer start: two-power locations of two bytes each per input
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dmaAddr_q <= adst_pkg::BASE_RST;
		end else begin
			dmaAddr_q <= dmaBase_q + (32'(dmaChanId) << (4'(bufLen) + 4'h1));
		end
	end

	assign ctrlOneRead = ctrlOne_q;
	always_comb begin
		ctrlTwoRead = 32'h0000_0000;
		ctrlTwoRead[adst_pkg::REF_READY_BIT]  = refReadyFlag;
		ctrlTwoRead[adst_pkg::REF_FAULT_BIT]  = refFault_q;
		ctrlTwoRead[adst_pkg::SCAN_DONE_BIT]  = scanDone_q;
		ctrlTwoRead[adst_pkg::CAP_SEL_LSB +: 3] = capSel_q;
	end

	// Read data stand one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdData_q <= 32'h0000_0000;
		end else if (regRead) begin
			unique case (regAddr)
				adst_pkg::CTRL_ONE_OFS:  rdData_q <= ctrlOneRead;
				adst_pkg::CTRL_TWO_OFS:  rdData_q <= ctrlTwoRead;
				adst_pkg::VEC_BASE_OFS:  rdData_q <= vecRead;
				adst_pkg::DMA_BASE_OFS:  rdData_q <= dmaBase_q;
				adst_pkg::SW_TRIG_OFS:   rdData_q <= {30'h0000_0000, swLevel_q, 1'b0};
				adst_pkg::DRDY_LOW_OFS:  rdData_q <= inputReadyLow;
				adst_pkg::DRDY_HIGH_OFS: rdData_q <= inputReadyHigh;
				default:                 rdData_q <= 32'h0000_0000;
			endcase
		end else begin
			rdData_q <= 32'h0000_0000;
		end
	end

	assign regRdData             = rdData_q;
	assign scanStart             = scanStart_q;
	assign dmaStartAddr          = dmaAddr_q;
	assign moduleRun             = running;
	assign inputPumpEnable       = ctrlOne_q[adst_pkg::PUMP_BIT];
	assign dividerSenseEnable    = ctrlOne_q[adst_pkg::DIV_SENSE_BIT];
	assign dmaClockSyncBypass    = ctrlOne_q[adst_pkg::DMA_BYP_BIT];
	assign periphClockSyncBypass = ctrlOne_q[adst_pkg::PER_BYP_BIT];
	assign dividerCapSelect      = capSel_q;

endmodule

// ===== pkg/adst_pkg.sv
// Register map, field positions, reset values and trigger codes of the scan control block
package adst_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] CTRL_ONE_OFS   = 8'h00;
	localparam logic [7:0] CTRL_TWO_OFS   = 8'h04;
	localparam logic [7:0] VEC_BASE_OFS   = 8'h08;
	localparam logic [7:0] DMA_BASE_OFS   = 8'h0c;
	localparam logic [7:0] SW_TRIG_OFS    = 8'h10;
	localparam logic [7:0] DRDY_LOW_OFS   = 8'h14;
	localparam logic [7:0] DRDY_HIGH_OFS  = 8'h18;

	// Control one fields
	localparam int TRIG_SEL_LSB    = 16;
	localparam int TRIG_SEL_W      = 5;
	localparam int ENABLE_BIT      = 15;
	localparam int IDLE_STOP_BIT   = 13;
	localparam int PUMP_BIT        = 12;
	localparam int DIV_SENSE_BIT   = 11;
	localparam int DMA_BYP_BIT     = 10;
	localparam int PER_BYP_BIT     = 9;
	localparam int VEC_SHIFT_LSB   = 4;
	localparam int SENS_BIT        = 3;
	localparam int BUF_LEN_LSB     = 0;

	// Control two fields
	localparam int REF_READY_BIT   = 31;
	localparam int REF_FAULT_BIT   = 30;
	localparam int SCAN_DONE_BIT   = 29;
	localparam int CAP_SEL_LSB     = 26;

	// Software trigger register fields
	localparam int SW_EDGE_BIT     = 0;
	localparam int SW_LEVEL_BIT    = 1;

	// Reset values
	localparam logic [31:0] CTRL_ONE_RST = 32'h0000_0000;
	localparam logic [2:0]  CAP_SEL_RST  = 3'h0;
	localparam logic [31:0] BASE_RST     = 32'h0000_0000;

	// Scan trigger select codes
	localparam logic [4:0] TRG_NONE      = 5'h00;
	localparam logic [4:0] TRG_SW_EDGE   = 5'h01;
	localparam logic [4:0] TRG_SW_LEVEL  = 5'h02;
	localparam logic [4:0] TRG_SCAN      = 5'h03;
	localparam logic [4:0] TRG_EXT_IRQ0  = 5'h04;
	localparam logic [4:0] TRG_TMR_FIRST = 5'h05;
	localparam logic [4:0] TRG_TMR_LAST  = 5'h07;
	localparam logic [4:0] TRG_PWM_FIRST = 5'h08;
	localparam logic [4:0] TRG_PWM_LAST  = 5'h0f;
	localparam logic [4:0] TRG_OC_FIRST  = 5'h10;
	localparam logic [4:0] TRG_OC_LAST   = 5'h13;
	localparam logic [4:0] TRG_CTU_TRIP  = 5'h14;
	localparam logic [4:0] TRG_CL_FIRST  = 5'h18;
	localparam logic [4:0] TRG_CL_LAST   = 5'h1d;

	// Pin synchroniser depth
	localparam int SYNC_STAGES     = 3;
endpackage

// ===== testbench/adst_ctrl_asserts.sv
// Port checker for the scan control block, with its bind
module adst_chk (
	// Clock, reset and register port
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWrData,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [31:0] regRdData,
	// Converter side and outputs
	input wire logic        idleMode,
	input wire logic        scanComplete,
	input wire logic [31:0] inputReadyLow,
	input wire logic [31:0] inputReadyHigh,
	input wire logic        scanStart,
	input wire logic [5:0]  dmaChanId,
	input wire logic [31:0] dmaStartAddr,
	input wire logic        moduleRun,
	input wire logic        inputPumpEnable,
	input wire logic        dividerSenseEnable,
	input wire logic        dmaClockSyncBypass,
	input wire logic        periphClockSyncBypass,
	input wire logic [2:0]  dividerCapSelect
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	logic [31:0] ctl_q, vb_q, db_q, vecExp, dmaExp;
	logic [2:0]  cap_q;
	logic [5:0]  low;
	logic        busy_q, done_q, up_q;
	wire  [63:0] rdy = {inputReadyHigh, inputReadyLow};
	wire         rdTwo = regRead && regAddr == adst_pkg::CTRL_TWO_OFS;
	always_comb begin
		low = 6'h0;
		for (int i = 63; i >= 0; i--)
			if (rdy[i])
				low = 6'(i);
		vecExp = vb_q + (32'(low) << ctl_q[6:4]);
		// Widened so that a length of 7 does not wrap the shift to zero
		dmaExp = db_q + (32'(dmaChanId) << ({1'b0, ctl_q[2:0]} + 4'h1));
	end
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst) begin
			ctl_q <= 32'h0;
			vb_q <= 32'h0;
			db_q <= 32'h0;
			cap_q <= 3'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			up_q <= 1'b0;
		end else begin
			if (regWrite && regAddr == adst_pkg::CTRL_ONE_OFS)
				ctl_q <= regWrData;
			if (regWrite && regAddr == adst_pkg::CTRL_TWO_OFS)
				cap_q <= regWrData[28:26];
			if (regWrite && regAddr == adst_pkg::VEC_BASE_OFS)
				vb_q <= regWrData;
			if (regWrite && regAddr == adst_pkg::DMA_BASE_OFS)
				db_q <= regWrData;
			up_q <= 1'b1;
			busy_q <= scanStart || (busy_q && !scanComplete);
			done_q <= (scanComplete && (busy_q || scanStart)) || (done_q && !rdTwo);
		end
	run_map_a: assert property (moduleRun == (ctl_q[15] && !(ctl_q[13] && idleMode)))
		else $error("run output wrong");
	static_out_a: assert property ({inputPumpEnable, dividerSenseEnable, dmaClockSyncBypass,
		periphClockSyncBypass} == ctl_q[12:9]) else $error("static control output wrong");
	cap_sel_a: assert property (dividerCapSelect == cap_q)
		else $error("capacitor select wrong");
	dma_addr_a: assert property (up_q |-> dmaStartAddr == $past(dmaExp))
		else $error("buffer start address wrong");
	one_shot_a: assert property (scanStart |=> !scanStart)
		else $error("scan start longer than one cycle");
	no_overlap_a: assert property (busy_q |-> !scanStart)
		else $error("scan started while one is active");
	idle_block_a: assert property (!moduleRun |=> !scanStart)
		else $error("scan started while halted");
	ready_off_a: assert property (rdTwo && !ctl_q[15] |=> !regRdData[31])
		else $error("reference ready shown while off");
	vec_read_a: assert property (regRead && regAddr == adst_pkg::VEC_BASE_OFS |=> regRdData == $past(vecExp))
		else $error("vector read wrong");
	done_flag_a: assert property (rdTwo |=> regRdData[29] == $past(done_q))
		else $error("scan done flag wrong");
	cover property (scanStart ##1 busy_q [*3]);
	cover property (rdTwo ##1 regRdData[29]);
	cover property (regRead && regAddr == adst_pkg::VEC_BASE_OFS && |inputReadyHigh);
endmodule
bind adst_ctrl adst_chk i_chk (.*);

// ===== testbench/adst_conv_model.sv
// Converter stand-in that finishes each scan after a set number of cycles
module adst_conv_model (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       nrst,
	// Scan handshake and answer delay
	input wire logic       scanStart,
	input wire logic [7:0] lat,
	output logic           scanComplete
);
	logic [7:0] cnt_q;
	// A start while counting restarts the count, so overlap shows up as a late answer
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst) begin
			cnt_q <= 8'h0;
			scanComplete <= 1'b0;
		end else begin
			scanComplete <= cnt_q == 8'h1;
			if (scanStart)
				cnt_q <= lat;
			else if (cnt_q != 8'h0)
				cnt_q <= cnt_q - 8'h1;
		end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the scan control block
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] C1 = adst_pkg::CTRL_ONE_OFS, C2 = adst_pkg::CTRL_TWO_OFS;
	localparam logic [7:0] VB = adst_pkg::VEC_BASE_OFS, SW = adst_pkg::SW_TRIG_OFS;
	logic        core_clk = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic        idleMode = 1'b0, refReadyPin = 1'b0, refFaultPin = 1'b0;
	logic        scanStart, scanComplete, moduleRun, inputPumpEnable, dividerSenseEnable;
	logic        dmaClockSyncBypass, periphClockSyncBypass;
	logic [2:0]  dividerCapSelect;
	logic [5:0]  dmaChanId = 6'h0;
	logic [7:0]  regAddr = 8'h0, lat = 8'h04;
	logic [31:0] regWrData = 32'h0, trigSources = 32'h0, inputReadyLow = 32'h0, inputReadyHigh = 32'h0;
	logic [31:0] regRdData, dmaStartAddr;
	int          err_count = 0, check_count = 0, cycles = 0;
	wire  [3:0]  statics = {inputPumpEnable, dividerSenseEnable, dmaClockSyncBypass, periphClockSyncBypass};

	adst_ctrl i_dut (.*);
	adst_conv_model i_model (.*);

	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask
	// Counts start pulses; each is one cycle wide, so every cycle is looked at
	task automatic starts(input int n, output int k);
		k = 0;
		repeat (n) begin
			@(posedge core_clk);
			#1 k += int'(scanStart);
		end
	endtask

	task automatic t_reset();
		logic [31:0] d;
		for (int a = 0; a <= 'h40; a += 4) begin
			rd(8'(a), d);
			`CHK(d, 32'h0)
		end
	endtask
	task automatic t_ctrl();
		logic [31:0] d;
		wr(C1, 32'hffff_5e7f);
		rd(C1, d);
		`CHK(d, 32'h001f_1e7f)
		`CHK(statics, 4'hf)
		`CHK(moduleRun, 1'b0)
		wr(C1, 32'h0000_a000);
		@(posedge core_clk) idleMode <= 1'b1;
		#1 `CHK(moduleRun, 1'b0)
		wr(C1, 32'h0000_8000);
		#1 `CHK(moduleRun, 1'b1)
		@(posedge core_clk) idleMode <= 1'b0;
		wr(C1, 32'h0);
		#1 `CHK({statics, moduleRun}, 5'h0)
	endtask
	task automatic t_vec();
		logic [31:0] d;
		wr(VB, 32'h0000_1000);
		@(posedge core_clk) inputReadyHigh <= 32'h0000_0108;
		rd(adst_pkg::DRDY_HIGH_OFS, d);
		`CHK(d, 32'h0000_0108)
		for (int s = 0; s < 8; s++) begin
			wr(C1, 32'(s) << 4);
			rd(VB, d);
			`CHK(d, 32'h1000 + (32'h23 << s))
		end
		@(posedge core_clk) inputReadyLow <= 32'h0000_0020;
		rd(VB, d);
		`CHK(d, 32'h1000 + (32'h5 << 7))
		@(posedge core_clk) inputReadyLow <= 32'h0;
		inputReadyHigh <= 32'h0;
	endtask
	task automatic t_dma();
		wr(adst_pkg::DMA_BASE_OFS, 32'h2000_0000);
		@(posedge core_clk) dmaChanId <= 6'h3f;
		for (int b = 0; b < 8; b++) begin
			wr(C1, 32'(b));
			repeat (2) @(posedge core_clk);
			#1 `CHK(dmaStartAddr, 32'h2000_0000 + (32'h3f << (b + 1)))
		end
	endtask
	task automatic t_codes();
		int k;
		for (int c = 0; c < 32; c++) begin
			wr(C1, 32'(c) << 16);
			wr(C1, (32'(c) << 16) | 32'h8000);
			if (c == 1 || c == 2)
				wr(SW, 32'(c));
			else
				@(posedge core_clk) trigSources <= 32'h1 << c;
			starts(30, k);
			`CHK(k, int'((c > 0 && c < 21) || (c > 23 && c < 30)))
			wr(SW, 32'h0);
			@(posedge core_clk) trigSources <= 32'h0;
			wr(C1, 32'h0);
		end
	endtask
	task automatic t_level();
		int k;
		wr(C1, 32'h0005_2008);
		wr(C1, 32'h0005_a008);
		@(posedge core_clk) trigSources <= 32'h20;
		starts(40, k);
		`CHK(k > 3, 1'b1)
		@(posedge core_clk) idleMode <= 1'b1;
		starts(10, k);
		starts(30, k);
		`CHK(k, 0)
		lat <= 8'h28;
		@(posedge core_clk) idleMode <= 1'b0;
		starts(30, k);
		`CHK(k, 1)
		wr(C1, 32'h0000_8008);
		starts(60, k);
		`CHK(k, 0)
		lat <= 8'h04;
		@(posedge core_clk) trigSources <= 32'h0;
		wr(C1, 32'h0);
	endtask
	task automatic t_status();
		logic [31:0] d;
		@(posedge core_clk) refReadyPin <= 1'b1;
		wr(C2, 32'hfc00_0000);
		rd(C2, d);
		// Scan done is still set from the last level scan: nothing has read it since
		`CHK(d, 32'h3c00_0000)
		`CHK(dividerCapSelect, 3'h7)
		wr(C1, 32'h0001_0000);
		wr(C1, 32'h0001_8000);
		repeat (6) @(posedge core_clk);
		refFaultPin <= 1'b1;
		repeat (6) @(posedge core_clk);
		refFaultPin <= 1'b0;
		wr(SW, 32'h1);
		repeat (12) @(posedge core_clk);
		rd(C2, d);
		`CHK(d, 32'hfc00_0000)
		rd(C2, d);
		`CHK(d[29], 1'b0)
		wr(C1, 32'h0);
		repeat (6) @(posedge core_clk);
		rd(C2, d);
		`CHK(d, 32'h1c00_0000)
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset();
		t_ctrl();
		t_vec();
		t_dma();
		t_codes();
		t_level();
		t_status();
		end_of_test();
	end
endmodule
